//--- tmc_regs.vh
// Purpose: shared constants for the timing controller
// Assumes: 16-bit internal registers, 8-bit command codes
// Notes: internal locations are picked by the data pointer
`ifndef TMC_REGS_VH
`define TMC_REGS_VH

// master mode bit positions
`define TMC_MM_FOG 12
`define TMC_MM_BUS16 13
`define TMC_MM_SEQDIS 14
`define TMC_MM_DEC 15
`define TMC_MM_RESET 16'h0000

// counter mode fields
`define TMC_CM_GC_HI 15
`define TMC_CM_GC_LO 13
`define TMC_CM_SRC_HI 10
`define TMC_CM_SRC_LO 8
`define TMC_CM_SG 7
`define TMC_CM_RS 6
`define TMC_CM_REP 5
`define TMC_CM_RESET 16'h0000

// data pointer: group in [4:2], element in [1:0]
`define TMC_GRP_MASTER 3'h7
`define TMC_EL_MODE 2'h0
`define TMC_EL_LOAD 2'h1
`define TMC_EL_HOLD 2'h2
`define TMC_PTR_RESET 5'h00

// command codes, control port low byte
`define TMC_CMD_PTR 3'h0
`define TMC_CMD_ARM 3'h1
`define TMC_CMD_DISARM 3'h2
`define TMC_CMD_LOAD 3'h3
`define TMC_CMD_SET_FOG 8'he1
`define TMC_CMD_CLR_FOG 8'he9
`define TMC_CMD_SET_BUS16 8'he2
`define TMC_CMD_CLR_BUS16 8'hea
`define TMC_CMD_SET_SEQDIS 8'he3
`define TMC_CMD_CLR_SEQDIS 8'heb
`define TMC_CMD_MRESET 8'hff

// scaler ratios per tap step
`define TMC_BIN_MAX 4'hf
`define TMC_DEC_MAX 4'h9

`endif

//--- tmc_scaler.v
// Purpose: tapped frequency scaler, binary or decimal steps
// Assumes: tap 0 is the oscillator rate (every cycle)
// Notes: taps are one-cycle enable pulses
`timescale 1ns/1ps
`include "tmc_regs.vh"
module tmc_scaler #(
  parameter DIGITS = 4
) (
  // clock and reset
  input wire clk,
  input wire rst,
  // ratio select
  input wire dec_sel,
  // tap enables
  output wire [DIGITS:0] tap_en
);
  wire [3:0] dig_max;
  wire [DIGITS:0] carry;
  assign dig_max = dec_sel ? `TMC_DEC_MAX : `TMC_BIN_MAX; // RL12 RL13
  assign carry[0] = 1'b1;
  assign tap_en = carry;
  genvar i;
  generate
    for (i = 0; i < DIGITS; i = i + 1) begin : g_dig
      reg [3:0] dig_q;
      assign carry[i+1] = carry[i] & (dig_q >= dig_max);
      always @(posedge clk or posedge rst) begin
        if (rst) begin
          dig_q <= 4'h0;
        end else if (carry[i]) begin
          // wrap at the step ratio, 16 binary or 10 decimal
          if (dig_q >= dig_max) begin
            dig_q <= 4'h0; // RL12 RL13
          end else begin
            dig_q <= dig_q + 4'h1;
          end
        end
      end
    end
  endgenerate
endmodule

//--- tmc_counter.v
// Purpose: one general down counter with mode A to L control
// Assumes: gate is already synchronised and ANDed with its aux gate
// Notes: special gate bit ignored; modes M to X not handled
`timescale 1ns/1ps
`include "tmc_regs.vh"
module tmc_counter (
  // clock and reset
  input wire clk,
  input wire rst,
  // count source and gate
  input wire src_en,
  input wire gate,
  // software strobes
  input wire arm,
  input wire disarm,
  input wire load_now,
  // configuration
  input wire [15:0] mode,
  input wire [15:0] load_val,
  input wire [15:0] hold_val,
  // state
  output reg [15:0] cnt_q,
  output reg tc_q,
  output reg armed_q
);
  wire [2:0] gc;
  wire rs;
  wire rep;
  wire gate_act;
  wire edge_mode;
  wire level_mode;
  wire gate_ok;
  wire go;
  reg gate_d_q;
  reg run_q;
  reg alt_q;
  reg stop_pend_q;
  reg disarm_pend_q;

  assign gc = mode[`TMC_CM_GC_HI:`TMC_CM_GC_LO];
  assign rs = mode[`TMC_CM_RS];
  assign rep = mode[`TMC_CM_REP];
  assign gate_act = gc[0] ? ~gate : gate;
  assign edge_mode = (gc[2:1] == 2'b11);
  assign level_mode = (gc != 3'h0) && !edge_mode;
  // gate qualification per mode
  assign gate_ok = (gc == 3'h0) ? 1'b1 : // RL19
                   level_mode ? gate_act : // RL20
                   run_q; // RL21 RL22
  // in terminal count the counter always moves
  assign go = src_en & (tc_q | (armed_q & gate_ok)); // RL24

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_q <= 16'h0000;
      tc_q <= 1'b0;
      armed_q <= 1'b0;
      gate_d_q <= 1'b0;
      run_q <= 1'b0;
      alt_q <= 1'b0;
      stop_pend_q <= 1'b0;
      disarm_pend_q <= 1'b0;
    end else begin
      gate_d_q <= gate_act;
      if (edge_mode && gate_act && !gate_d_q) begin
        run_q <= 1'b1; // RL21 RL22
      end
      if (load_now) begin
        cnt_q <= load_val;
        alt_q <= 1'b0;
        tc_q <= 1'b0;
      end else if (go) begin
        if (tc_q) begin
          // stop or disarm only once leaving terminal count
          cnt_q <= cnt_q - 16'h0001;
          tc_q <= 1'b0;
          stop_pend_q <= 1'b0;
          disarm_pend_q <= 1'b0;
          if (stop_pend_q) begin
            run_q <= 1'b0; // RL24
          end
          if (disarm_pend_q) begin
            armed_q <= 1'b0; // RL24
          end
        end else if (cnt_q == 16'h0001) begin
          tc_q <= 1'b1;
          if (rs && !alt_q) begin
            cnt_q <= hold_val; // RL15
            alt_q <= 1'b1;
          end else begin
            cnt_q <= load_val; // RL14 RL15
            alt_q <= 1'b0;
          end
          // first terminal count, or second when alternating
          stop_pend_q <= !rs || alt_q; // RL21 RL22
          disarm_pend_q <= !rep && (!rs || alt_q); // RL16 RL17 RL18
        end else begin
          cnt_q <= cnt_q - 16'h0001;
        end
      end
      if (arm) begin
        armed_q <= 1'b1;
      end else if (disarm) begin
        armed_q <= 1'b0;
      end
    end
  end
endmodule

//--- tmc_top.v
// Purpose: master mode and counter mode control of a five counter timer
// Assumes: host strobes are one-cycle pulses on CORE_CLK
// Notes: gate pins and aux gate lines pass a two stage synchroniser
// How it works
// RL1 - gate bit set forces frequency output low, driven.
// RL2 - set and clear commands change gate bit alone; master writes too.
// RL3 - after reset the frequency output is gated on.
// RL4 - wide bus moves whole words; byte pointer stays set.
// RL5 - narrow bus moves two bytes on low lines; pointer toggles.
// RL6 - narrow bus uses upper lines eight to twelve as aux gates.
// RL7 - effective gate is normal gate ANDed with aux gate.
// RL8 - host holds lines thirteen to fifteen high in narrow mode.
// RL9 - sequencing disabled: pointer changes only by pointer command.
// RL10 - sequencing enabled: pointer advances after each word, except in the master group, where it stays.
// RL11 - sequencing bit written via master mode or set/clear commands.
// RL12 - binary scaler taps divide by sixteen per step.
// RL13 - decimal scaler taps divide by ten per step.
// RL14 - modes A to F reload from load register each terminal count.
// RL15 - modes G to L alternate reload between load and hold.
// RL16 - modes A, B, C count to terminal count once, then disarm.
// RL17 - modes G, H, I reach terminal count twice, then disarm.
// RL18 - repetition set: count repeatedly and never disarm.
// RL19 - gate field zero: gate has no effect.
// RL20 - level gate: count only while gate is active.
// RL21 - edge gate, single reload: start on edge, stop at next count end.
// RL22 - edge gate, alternating: start on edge, stop at second count end.
// RL23 - reset or master reset command clears master mode to zero.
// RL24 - terminal count state always counts; stop only after it ends.
`timescale 1ns/1ps
`include "tmc_regs.vh"
module tmc_top #(
  parameter NCNT = 5
) (
  // clock and reset
  input wire CORE_CLK,
  input wire RST,
  // host strobes
  input wire CTRL_SEL,
  input wire WR_STB,
  input wire RD_STB,
  // data bus
  input wire [15:0] DB_IN,
  output reg [15:0] DB_OUT,
  output reg DB_OE,
  // counter gates
  input wire [4:0] GATE_IN,
  // counter state
  output reg [4:0] CNT_TC,
  // frequency output
  output reg FREQ_OUT,
  output wire FREQ_OUT_OE
);
  reg [15:0] mm_q;
  reg [15:0] cm_q [0:NCNT-1];
  reg [15:0] load_q [0:NCNT-1];
  reg [15:0] hold_q [0:NCNT-1];
  reg [4:0] ptr_q;
  reg bptr_q;
  reg [7:0] lo_q;
  reg [4:0] gate_s1_q;
  reg [4:0] gate_s2_q;
  reg [4:0] aux_s1_q;
  reg [4:0] aux_s2_q;
  reg [15:0] rd_word;
  reg [4:0] ptr_nx;
  wire bus16;
  wire seq_dis;
  wire cmd_wr;
  wire dat_wr;
  wire dat_rd;
  wire word_wr;
  wire word_rd;
  wire [15:0] wr_word;
  wire [2:0] grp;
  wire [1:0] el;
  wire [4:0] tap_en;
  wire [4:0] tc_w;
  wire [4:0] cnt_arm;
  wire [4:0] cnt_disarm;
  wire [4:0] cnt_load;
  wire [7:0] status;
  integer k;

  assign bus16 = mm_q[`TMC_MM_BUS16];
  assign seq_dis = mm_q[`TMC_MM_SEQDIS];
  assign cmd_wr = WR_STB & CTRL_SEL;
  assign dat_wr = WR_STB & ~CTRL_SEL;
  assign dat_rd = RD_STB & ~CTRL_SEL;
  // a word completes on the second byte in narrow mode
  assign word_wr = dat_wr & (bus16 | ~bptr_q); // RL4 RL5
  assign word_rd = dat_rd & (bus16 | ~bptr_q); // RL4 RL5
  assign wr_word = bus16 ? DB_IN : {DB_IN[7:0], lo_q}; // RL4 RL5
  assign grp = ptr_q[4:2];
  assign el = ptr_q[1:0];
  assign status = {2'b00, tc_w, bptr_q};
  assign FREQ_OUT_OE = 1'b1; // RL1

  // counter commands carry a counter mask in the low five bits
  assign cnt_arm = (cmd_wr && DB_IN[7:5] == `TMC_CMD_ARM) ? DB_IN[4:0] : 5'h00;
  assign cnt_disarm = (cmd_wr && DB_IN[7:5] == `TMC_CMD_DISARM) ? DB_IN[4:0] : 5'h00;
  assign cnt_load = (cmd_wr && DB_IN[7:5] == `TMC_CMD_LOAD) ? DB_IN[4:0] : 5'h00;

  // read mux and pointer sequencing
  always @* begin
    rd_word = 16'h0000;
    if (grp == `TMC_GRP_MASTER) begin
      rd_word = mm_q;
    end else if (grp < NCNT) begin
      case (el)
        `TMC_EL_MODE: rd_word = cm_q[grp];
        `TMC_EL_LOAD: rd_word = load_q[grp];
        `TMC_EL_HOLD: rd_word = hold_q[grp];
        default: rd_word = 16'h0000;
      endcase
    end
    ptr_nx = ptr_q;
    if (grp != `TMC_GRP_MASTER) begin
      if (el >= `TMC_EL_HOLD) begin
        ptr_nx = {((grp >= NCNT - 1) ? 3'h0 : grp + 3'h1), `TMC_EL_MODE}; // RL10
      end else begin
        ptr_nx = {grp, el + 2'h1}; // RL10
      end
    end
  end

  // gate synchronisers
  always @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      gate_s1_q <= 5'h00;
      gate_s2_q <= 5'h00;
      aux_s1_q <= 5'h00;
      aux_s2_q <= 5'h00;
    end else begin
      gate_s1_q <= GATE_IN;
      gate_s2_q <= gate_s1_q;
      aux_s1_q <= DB_IN[12:8]; // RL6
      aux_s2_q <= aux_s1_q;
    end
  end

  // host register file, pointer and commands
  always @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      mm_q <= `TMC_MM_RESET; // RL3 RL23
      ptr_q <= `TMC_PTR_RESET;
      bptr_q <= 1'b1;
      lo_q <= 8'h00;
      DB_OUT <= 16'h0000;
      DB_OE <= 1'b0;
      for (k = 0; k < NCNT; k = k + 1) begin
        cm_q[k] <= `TMC_CM_RESET;
        load_q[k] <= 16'h0000;
        hold_q[k] <= 16'h0000;
      end
    end else begin
      DB_OE <= RD_STB;
      if (cmd_wr) begin
        if (DB_IN[7:5] == `TMC_CMD_PTR) begin
          ptr_q <= DB_IN[4:0]; // RL9
          bptr_q <= 1'b1;
        end
        case (DB_IN[7:0])
          `TMC_CMD_SET_FOG: mm_q[`TMC_MM_FOG] <= 1'b1; // RL2
          `TMC_CMD_CLR_FOG: mm_q[`TMC_MM_FOG] <= 1'b0; // RL2
          `TMC_CMD_SET_BUS16: mm_q[`TMC_MM_BUS16] <= 1'b1;
          `TMC_CMD_CLR_BUS16: mm_q[`TMC_MM_BUS16] <= 1'b0;
          `TMC_CMD_SET_SEQDIS: mm_q[`TMC_MM_SEQDIS] <= 1'b1; // RL11
          `TMC_CMD_CLR_SEQDIS: mm_q[`TMC_MM_SEQDIS] <= 1'b0; // RL11
          `TMC_CMD_MRESET: begin
            mm_q <= `TMC_MM_RESET; // RL23
            bptr_q <= 1'b1;
          end
          default: begin
          end
        endcase
      end else if (dat_wr) begin
        if (!word_wr) begin
          lo_q <= DB_IN[7:0];
          bptr_q <= 1'b0; // RL5
        end else begin
          bptr_q <= 1'b1; // RL4 RL5
          if (!seq_dis) begin
            ptr_q <= ptr_nx; // RL9 RL10
          end
          if (grp == `TMC_GRP_MASTER) begin
            mm_q <= wr_word; // RL2 RL11
          end else if (grp < NCNT) begin
            case (el)
              `TMC_EL_MODE: cm_q[grp] <= wr_word;
              `TMC_EL_LOAD: load_q[grp] <= wr_word;
              `TMC_EL_HOLD: hold_q[grp] <= wr_word;
              default: begin
              end
            endcase
          end
        end
      end else if (RD_STB) begin
        if (CTRL_SEL) begin
          DB_OUT <= {8'h00, status};
        end else if (bus16) begin
          DB_OUT <= rd_word; // RL4
          if (!seq_dis) begin
            ptr_q <= ptr_nx; // RL10
          end
        end else if (bptr_q) begin
          DB_OUT <= {8'h00, rd_word[7:0]}; // RL5
          bptr_q <= 1'b0;
        end else begin
          DB_OUT <= {8'h00, rd_word[15:8]}; // RL5
          bptr_q <= 1'b1;
          if (!seq_dis) begin
            ptr_q <= ptr_nx; // RL10
          end
        end
      end
      if (bus16) begin
        bptr_q <= 1'b1; // RL4
      end
    end
  end

  // frequency output, gated low by master mode
  always @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      FREQ_OUT <= 1'b0;
      CNT_TC <= 5'h00;
    end else begin
      CNT_TC <= tc_w;
      if (mm_q[`TMC_MM_FOG]) begin
        FREQ_OUT <= 1'b0; // RL1
      end else if (tap_en[1]) begin
        FREQ_OUT <= ~FREQ_OUT; // RL3
      end
    end
  end

  tmc_scaler #(
    .DIGITS(4)
  ) u_scaler (
    .clk(CORE_CLK),
    .rst(RST),
    .dec_sel(mm_q[`TMC_MM_DEC]),
    .tap_en(tap_en)
  );

  genvar g;
  generate
    for (g = 0; g < NCNT; g = g + 1) begin : g_cnt
      wire [2:0] src_sel;
      wire src_en;
      wire gate_eff;
      assign src_sel = cm_q[g][`TMC_CM_SRC_HI:`TMC_CM_SRC_LO];
      assign src_en = (src_sel < 3'h5) ? tap_en[src_sel] : tap_en[0];
      // aux gate only counts while the bus is narrow
      assign gate_eff = gate_s2_q[g] & (bus16 | aux_s2_q[g]); // RL6 RL7
      tmc_counter u_cnt (
        .clk(CORE_CLK),
        .rst(RST),
        .src_en(src_en),
        .gate(gate_eff),
        .arm(cnt_arm[g]),
        .disarm(cnt_disarm[g]),
        .load_now(cnt_load[g]),
        .mode(cm_q[g]),
        .load_val(load_q[g]),
        .hold_val(hold_q[g]),
        .cnt_q(),
        .tc_q(tc_w[g]),
        .armed_q()
      );
    end
  endgenerate
endmodule

//--- tmc_top_props.sv
`timescale 1ns/1ps
// Purpose: port checker for the timer control block
// Assumes: one-cycle host strobes
// Notes: bus width tracked from commands only
module tmc_top_props #(
  parameter NCNT = 5
) (
  // clock and reset
  input wire CORE_CLK,
  input wire RST,
  // host side
  input wire CTRL_SEL,
  input wire WR_STB,
  input wire RD_STB,
  input wire [15:0] DB_IN,
  input wire [15:0] DB_OUT,
  input wire DB_OE,
  // counters and frequency output
  input wire [4:0] GATE_IN,
  input wire [4:0] CNT_TC,
  input wire FREQ_OUT,
  input wire FREQ_OUT_OE
);
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (RST);
  wire cmd_w = WR_STB && CTRL_SEL;
  logic wide_q;
  always @(posedge CORE_CLK or posedge RST)
    if (RST) wide_q <= 1'b0;
    else if (cmd_w && DB_IN[7:0] == 8'he2) wide_q <= 1'b1;
    else if (cmd_w && (DB_IN[7:0] == 8'hea || DB_IN[7:0] == 8'hff)) wide_q <= 1'b0;
  AST_RD_OE: assert property (RD_STB |=> DB_OE)
    else $error("read without output enable");
  AST_OE_CAUSE: assert property (DB_OE |-> $past(RD_STB))
    else $error("output enable without read");
  AST_FREQ_OUT_PIN_DRIVEN: assert property (FREQ_OUT_OE)
    else $error("frequency pin released");
  AST_GATE_OFF: assert property (cmd_w && DB_IN[7:0] == 8'he1 |-> ##3 !FREQ_OUT [*8])
    else $error("frequency output not gated off");
  AST_GATE_ON: assert property (cmd_w && DB_IN[7:0] == 8'he9 |-> ##[3:40] $changed(FREQ_OUT))
    else $error("frequency output not running");
  AST_RESET_RUN: assert property ($fell(RST) |-> ##[1:40] $changed(FREQ_OUT))
    else $error("frequency output idle after reset");
  AST_MRESET: assert property (cmd_w && DB_IN[7:0] == 8'hff |-> ##[3:40] $changed(FREQ_OUT))
    else $error("gate bit kept after master reset");
  AST_WIDE_PTR: assert property (wide_q && CTRL_SEL && RD_STB |=> DB_OUT[0])
    else $error("byte pointer clear in wide mode");
  AST_NARROW_HI: assert property (!wide_q && RD_STB |=> DB_OUT[15:8] == 8'h00)
    else $error("upper byte driven in narrow mode");
  cover property (cmd_w && DB_IN[7:0] == 8'he1);
  cover property (wide_q && RD_STB);
  cover property ($rose(CNT_TC[0]));
endmodule

//--- tmc_host.sv
`timescale 1ns/1ps
// Purpose: host processor model on the timer bus
// Assumes: strobes last one clock, read data one clock later
// Notes: narrow mode keeps upper lines at aux gates and high
module tmc_host (
  // clock
  input wire logic clk,
  // bus
  output logic ctrl_sel,
  output logic wr_stb,
  output logic rd_stb,
  output logic [15:0] db,
  input wire logic [15:0] dout
);
  logic wide = 1'b0;
  logic [4:0] aux = 5'h1f;
  initial begin
    ctrl_sel = 1'b0;
    wr_stb = 1'b0;
    rd_stb = 1'b0;
    db = 16'hffff;
  end
  task automatic put(input logic c, input logic [15:0] d);
    @(posedge clk);
    ctrl_sel <= c;
    wr_stb <= 1'b1;
    db <= d;
    @(posedge clk);
    wr_stb <= 1'b0;
    db <= wide ? ~d : {3'h7, aux, ~d[7:0]};
  endtask
  task automatic cmd(input logic [7:0] c);
    put(1'b1, {3'h7, aux, c});
  endtask
  task automatic wr(input logic [15:0] w);
    if (wide) put(1'b0, w);
    else begin
      put(1'b0, {3'h7, aux, w[7:0]});
      put(1'b0, {3'h7, aux, w[15:8]});
    end
  endtask
  task automatic rd1(input logic c, output logic [15:0] v);
    @(posedge clk);
    ctrl_sel <= c;
    rd_stb <= 1'b1;
    @(posedge clk);
    rd_stb <= 1'b0;
    @(posedge clk);
    v = dout;
  endtask
  task automatic rd(output logic [15:0] v);
    logic [15:0] lo;
    logic [15:0] hi;
    rd1(1'b0, lo);
    if (wide) v = lo;
    else begin
      rd1(1'b0, hi);
      v = {hi[7:0], lo[7:0]};
    end
  endtask
endmodule

//--- tmc_top_tb.sv
`timescale 1ns/1ps
// Purpose: self-checking bench for the timer control block
// Assumes: counter one counts every clock from tap zero
// Notes: counter modes run from a table
module tmc_top_tb;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic [4:0] gate_in = 5'h00;
  wire ctrl_sel, wr_stb, rd_stb, db_oe, freq_out, freq_out_oe;
  wire [15:0] db_in, db_out;
  wire [4:0] cnt_tc;
  int n_fail = 0;
  int comparisons = 0;
  int cyc = 0;
  int hp;
  logic [15:0] v;
  typedef struct {logic [15:0] mode; logic [1:0] g; logic a; int n;} tmc_row_t;
  // mode, gate (0 low, 1 high, 2 rising), aux gate, tc count (3 = many)
  tmc_row_t rows[14] = '{
    '{16'h0000, 0, 1, 1}, '{16'h0040, 0, 1, 2}, '{16'h0020, 0, 1, 3},
    '{16'h0060, 0, 1, 3}, '{16'h4000, 0, 1, 0}, '{16'h4000, 1, 1, 1},
    '{16'h4000, 1, 0, 0}, '{16'h4020, 1, 1, 3}, '{16'h4040, 1, 1, 2},
    '{16'h4060, 0, 1, 0}, '{16'hc000, 2, 1, 1}, '{16'hc020, 2, 1, 1},
    '{16'hc040, 2, 1, 2}, '{16'hc060, 2, 1, 2}};
  always #4 core_clk = ~core_clk;
  tmc_top tmc_top_i (.CORE_CLK(core_clk), .RST(rst), .CTRL_SEL(ctrl_sel), .WR_STB(wr_stb),
    .RD_STB(rd_stb), .DB_IN(db_in), .DB_OUT(db_out), .DB_OE(db_oe), .GATE_IN(gate_in),
    .CNT_TC(cnt_tc), .FREQ_OUT(freq_out), .FREQ_OUT_OE(freq_out_oe));
  tmc_host tmc_host_i (.clk(core_clk), .ctrl_sel(ctrl_sel), .wr_stb(wr_stb),
    .rd_stb(rd_stb), .db(db_in), .dout(db_out));
  task automatic stop_test;
    if (n_fail == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input string s, input logic [15:0] e, input logic [15:0] g);
    comparisons++;
    if (g !== e) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic half(output int w);
    logic f;
    @(posedge core_clk);
    f = freq_out;
    for (w = 0; w < 99 && freq_out === f; w++) @(posedge core_clk);
    f = freq_out;
    for (w = 0; w < 99 && freq_out === f; w++) @(posedge core_clk);
  endtask
  task automatic mwr(input logic [15:0] w);
    tmc_host_i.cmd(8'h1c);
    tmc_host_i.wr(w);
  endtask
  task automatic mchk(input logic [15:0] e);
    logic [15:0] m;
    tmc_host_i.cmd(8'h1c);
    tmc_host_i.rd(m);
    chk("master mode", e, m);
  endtask
  task automatic run(input tmc_row_t r);
    int n;
    int t0;
    int t1;
    logic p;
    tmc_host_i.cmd(8'h41);
    gate_in <= {5{r.g == 2'd1}};
    tmc_host_i.aux = {5{r.a}};
    tmc_host_i.cmd(8'h00);
    tmc_host_i.wr(r.mode);
    tmc_host_i.wr(16'h0003);
    tmc_host_i.wr(16'h0008);
    tmc_host_i.cmd(8'h61);
    tmc_host_i.cmd(8'h21);
    n = 0;
    t0 = 0;
    t1 = 0;
    p = 1'b0;
    for (int i = 0; i < 60; i++) begin
      @(posedge core_clk);
      if (i == 5 && r.g == 2'd2) gate_in <= 5'h1f;
      if (cnt_tc[0] === 1'b1 && p !== 1'b1) begin
        n++;
        if (n == 1) t0 = i;
        if (n == 2) t1 = i;
      end
      p = cnt_tc[0];
    end
    chk("tc count", 16'(r.n), 16'(n < 3 ? n : 3));
    if (r.n > 1) chk("tc gap", r.mode[6] ? 16'd8 : 16'd3, 16'(t1 - t0));
  endtask
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 6000) begin
      n_fail++;
      stop_test();
    end
  end
  initial begin
    repeat (6) @(posedge core_clk);
    rst <= 1'b0;
    foreach (rows[i]) run(rows[i]);
    rst <= 1'b1;
    repeat (6) @(posedge core_clk);
    rst <= 1'b0;
    tmc_host_i.rd1(1'b1, v);
    chk("status", 16'h0001, v);
    half(hp);
    chk("half period", 16'd16, 16'(hp));
    mchk(16'h0000);
    mwr(16'h1000);
    half(hp);
    chk("gated", 16'd99, 16'(hp));
    chk("gated level", 16'h0000, {15'h0, freq_out});
    tmc_host_i.cmd(8'he9);
    mchk(16'h0000);
    tmc_host_i.cmd(8'he1);
    mchk(16'h1000);
    tmc_host_i.cmd(8'hff);
    mchk(16'h0000);
    mwr(16'h8000);
    half(hp);
    chk("half period", 16'd10, 16'(hp));
    mwr(16'h0000);
    tmc_host_i.cmd(8'he3);
    mchk(16'h4000);
    tmc_host_i.cmd(8'h00);
    tmc_host_i.wr(16'h1234);
    tmc_host_i.wr(16'h0005);
    tmc_host_i.cmd(8'h00);
    tmc_host_i.rd(v);
    chk("no advance", 16'h0005, v);
    tmc_host_i.cmd(8'heb);
    tmc_host_i.cmd(8'h00);
    tmc_host_i.wr(16'h0001);
    tmc_host_i.wr(16'h0077);
    tmc_host_i.cmd(8'h01);
    tmc_host_i.rd(v);
    chk("advance", 16'h0077, v);
    tmc_host_i.cmd(8'h01);
    tmc_host_i.put(1'b0, 16'hff11);
    tmc_host_i.rd1(1'b1, v);
    chk("byte pointer", 16'h0000, v);
    tmc_host_i.put(1'b0, 16'hff22);
    tmc_host_i.rd1(1'b1, v);
    chk("byte pointer", 16'h0001, v);
    tmc_host_i.cmd(8'he2);
    tmc_host_i.wide = 1'b1;
    tmc_host_i.cmd(8'h02);
    tmc_host_i.wr(16'ha5c3);
    tmc_host_i.cmd(8'h02);
    tmc_host_i.rd(v);
    chk("wide word", 16'ha5c3, v);
    tmc_host_i.rd1(1'b1, v);
    chk("wide pointer", 16'h0001, v);
    tmc_host_i.cmd(8'hea);
    tmc_host_i.wide = 1'b0;
    stop_test();
  end
endmodule
bind tmc_top tmc_top_props #(.NCNT(NCNT)) tmc_top_props_i (.CORE_CLK(CORE_CLK), .RST(RST),
  .CTRL_SEL(CTRL_SEL), .WR_STB(WR_STB), .RD_STB(RD_STB), .DB_IN(DB_IN), .DB_OUT(DB_OUT),
  .DB_OE(DB_OE), .GATE_IN(GATE_IN), .CNT_TC(CNT_TC), .FREQ_OUT(FREQ_OUT),
  .FREQ_OUT_OE(FREQ_OUT_OE));
